// ---- pkg/irct_pkg.sv ----
// Behaviour
// - detect edges on the chosen capture pin as selected by the edge field
// - drop input pulses narrower than the programmed glitch width
// - disabled short timer output holds the inverse of its initial bit
// - enabling short timer drives initial level, loads low or high reload
// - one-shot short timer stops at zero, toggles, flags and interrupts
// - repeat short timer toggles and reloads; flags once per full cycle
// - reload registers writable anytime; new values used at next load
// - short count of one forbidden; zero wraps to FF without timeout
// - measure mode short timer starts at first edge, then captures complemented count at each later edge
// - measure mode short timer flags timeout at zero, continues from FF
// - disabled long output is inverse of initial bit; submodes force it
// - long timer loads upper*256+lower, toggles and flags at zero
// - long count of one forbidden; zero wraps to FFFF without timeout
// - long measure captures and reloads at first edge after enabling
// - long capture bit clear: each edge captures, flags, reloads FFFF
// - long capture bit set: edges ignored, short timeout captures count
// - writing capture bit 0 then 1 re-arms long timer for next edge
// - long measure timer flags timeout at zero and continues from FFFF
// - ping-pong: each one-shot timer at terminal hands over to the other
// - submode 00 ends ping-pong; enter it with timers stopped
// - timer outputs reach their pins when routed; combined pin too, in carrier mode only
// - mode bit selects carrier generate at 0, pulse measure at 1
// - status flags clear on writing one; writing zero has no effect
// - logic field combines outputs as AND, OR, NOR or NAND
package irct_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] OFF_SHORT_LOW   = 4'h0;
  localparam logic [3:0] OFF_SHORT_HIGH  = 4'h1;
  localparam logic [3:0] OFF_LONG_LOWER  = 4'h2;
  localparam logic [3:0] OFF_LONG_UPPER  = 4'h3;
  localparam logic [3:0] OFF_SHORT_RISE  = 4'h4;
  localparam logic [3:0] OFF_SHORT_FALL  = 4'h5;
  localparam logic [3:0] OFF_LCAP_LOWER  = 4'h6;
  localparam logic [3:0] OFF_LCAP_UPPER  = 4'h7;
  localparam logic [3:0] OFF_SHORT_CTL   = 4'h8;
  localparam logic [3:0] OFF_SHARED_CTL  = 4'h9;
  localparam logic [3:0] OFF_LONG_CTL    = 4'hA;

  // ****************************************
  // field positions
  // ****************************************
  localparam int B_EN     = 7;
  localparam int B_SINGLE = 6;
  localparam int B_TOUT   = 5;
  localparam int B_CLK_HI = 4;
  localparam int B_CLK_LO = 3;
  localparam int B_CAPM   = 2;
  localparam int B_TOUTM  = 1;
  localparam int B_PIN    = 0;
  localparam int B_MODE   = 7;
  localparam int B_COMB   = 6;
  localparam int B_LOG_HI = 5;
  localparam int B_LOG_LO = 4;
  localparam int B_SUB_HI = 3;
  localparam int B_SUB_LO = 2;
  localparam int B_INIT_S = 1;
  localparam int B_INIT_L = 0;

  // ****************************************
  // reset values and constants
  // ****************************************
  localparam logic [7:0]  CTL_RST   = 8'h00;
  localparam logic [7:0]  RELOAD_RST = 8'h00;
  localparam logic [7:0]  SHORT_FULL = 8'hFF;
  localparam logic [15:0] LONG_FULL  = 16'hFFFF;
  localparam logic [2:0]  GLITCH_W0  = 3'h0;
  localparam logic [2:0]  GLITCH_W1  = 3'h1;
  localparam logic [2:0]  GLITCH_W2  = 3'h3;
  localparam logic [2:0]  GLITCH_W3  = 3'h7;

  typedef enum logic [1:0] {
    SUB_NORMAL   = 2'b00,
    SUB_PINGPONG = 2'b01,
    SUB_FORCE0   = 2'b10,
    SUB_FORCE1   = 2'b11
  } irct_sub_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_COUNT = 2'b10
  } irct_run_e;

endpackage : irct_pkg

// ---- logic/irct_edge_filter.sv ----
`timescale 1ns/1ns
module irct_edge_filter (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       tick,
  // signal and settings
  input  wire logic       sample_in,
  input  wire logic [1:0] width_sel,
  input  wire logic [1:0] edge_sel,
  // edge pulses
  output logic            rise_pulse,
  output logic            fall_pulse
);

  logic       stable_r;
  logic [2:0] run_r;
  logic [2:0] width;

  always_comb begin
    case (width_sel)
      2'b00:   width = irct_pkg::GLITCH_W0;
      2'b01:   width = irct_pkg::GLITCH_W1;
      2'b10:   width = irct_pkg::GLITCH_W2;
      default: width = irct_pkg::GLITCH_W3;
    endcase
  end

  // a level must differ for more than width ticks to be taken
  always_ff @(posedge clock) begin
    if (reset) begin
      stable_r <= 1'b0;
      run_r    <= 3'h0;
    end else if (sample_in == stable_r) begin
      run_r <= 3'h0;
    end else if (tick) begin
      if (run_r >= width) begin
        stable_r <= sample_in;
        run_r    <= 3'h0;
      end else begin
        run_r <= run_r + 3'h1;
      end
    end
  end

  // 00 falling, 01 rising, 1x both
  always_ff @(posedge clock) begin
    if (reset) begin
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end else begin
      rise_pulse <= tick && sample_in != stable_r && run_r >= width
                    && sample_in && (edge_sel != 2'b00);
      fall_pulse <= tick && sample_in != stable_r && run_r >= width
                    && !sample_in && (edge_sel != 2'b01);
    end
  end

endmodule : irct_edge_filter

// ---- logic/irct_top.sv ----
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
module irct_top (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       we,
  input  wire logic       re,
  output logic      [7:0] rdata,
  // capture inputs
  input  wire logic       capture_input_pin_a,
  input  wire logic       capture_input_pin_b,
  // plain port levels when a pin is not routed
  input  wire logic       port_short,
  input  wire logic       port_long,
  input  wire logic       port_comb,
  // pins and interrupt requests
  output logic            short_output_pin,
  output logic            long_output_pin,
  output logic            combined_output_pin,
  output logic            short_irq,
  output logic            long_irq
);

  // ****************************************
  // storage
  // ****************************************
  logic [7:0]  short_low_r, short_high_r, long_lower_r, long_upper_r;
  logic [7:0]  short_rise_r, short_fall_r, lcap_lower_r, lcap_upper_r;
  logic [7:0]  short_ctl_r, shared_ctl_r, long_ctl_r;
  logic [7:0]  short_ctl_nxt, shared_ctl_nxt, long_ctl_nxt;
  logic [7:0]  short_cnt_r;
  logic [15:0] long_cnt_r;
  logic [1:0]  short_st_r, long_st_r;
  logic        short_out_r, long_out_r;
  logic        short_en_q, long_en_q, long_ign_q;
  logic [2:0]  pre_r;
  logic        rise, fall, edge_any;

  function automatic logic tick_of(input logic [1:0] sel,
                                   input logic [2:0] pre);
    case (sel)
      2'b00:   tick_of = 1'b1;
      2'b01:   tick_of = pre[0] == 1'b0;
      2'b10:   tick_of = pre[1:0] == 2'b00;
      default: tick_of = pre == 3'h0;
    endcase
  endfunction : tick_of

  function automatic logic comb_of(input logic [1:0] sel,
                                   input logic a, input logic b);
    case (sel)
      2'b00:   comb_of = a & b;
      2'b01:   comb_of = a | b;
      2'b10:   comb_of = ~(a | b);
      default: comb_of = ~(a & b);
    endcase
  endfunction : comb_of

  // ****************************************
  // decode
  // ****************************************
  wire wr_sc = we && addr == irct_pkg::OFF_SHORT_CTL;
  wire wr_xc = we && addr == irct_pkg::OFF_SHARED_CTL;
  wire wr_lc = we && addr == irct_pkg::OFF_LONG_CTL;
  wire mode     = shared_ctl_r[irct_pkg::B_MODE];
  wire [1:0] sub = shared_ctl_r[irct_pkg::B_SUB_HI:irct_pkg::B_SUB_LO];
  wire pingpong = !mode && sub == irct_pkg::SUB_PINGPONG;
  wire init_s   = shared_ctl_r[irct_pkg::B_INIT_S];
  wire init_l   = shared_ctl_r[irct_pkg::B_INIT_L];
  wire s_en     = short_ctl_r[irct_pkg::B_EN];
  wire l_en     = long_ctl_r[irct_pkg::B_EN];
  wire s_single = short_ctl_r[irct_pkg::B_SINGLE];
  wire l_single = long_ctl_r[irct_pkg::B_SINGLE];
  wire l_ign    = long_ctl_r[irct_pkg::B_SINGLE];
  wire s_tick = tick_of(short_ctl_r[irct_pkg::B_CLK_HI:irct_pkg::B_CLK_LO],
                        pre_r);
  wire l_tick = tick_of(long_ctl_r[irct_pkg::B_CLK_HI:irct_pkg::B_CLK_LO],
                        pre_r);
  wire s_start = s_en && !short_en_q;
  wire l_start = l_en && !long_en_q;
  wire s_run = s_en && !s_start && short_st_r == irct_pkg::ST_COUNT;
  wire l_run = l_en && !l_start && long_st_r == irct_pkg::ST_COUNT;
  // terminal is the tick that takes the count from 1 to 0
  wire s_term   = !mode && s_run && s_tick && short_cnt_r == 8'h01;
  wire l_term   = !mode && l_run && l_tick && long_cnt_r == 16'h0001;
  wire s_zero_m = mode && s_run && s_tick && short_cnt_r == 8'h01;
  wire l_zero_m = mode && l_run && l_tick && long_cnt_r == 16'h0001;
  wire s_cap = mode && s_run && edge_any;
  wire l_armed = l_en && !l_start && long_st_r == irct_pkg::ST_ARMED;
  wire l_cap_first = mode && l_armed && edge_any;
  wire l_cap_edge  = mode && l_run && !l_ign && edge_any;
  wire l_cap_tout  = mode && l_run && l_ign && s_zero_m;
  wire l_rearm = mode && l_en && l_ign && !long_ign_q;
  // repeat mode flags only when the level returns to its initial value
  wire s_tout_set = (s_term && (s_single || ~short_out_r == init_s))
                    || s_zero_m;
  wire l_tout_set = l_term || l_zero_m;
  wire rise_set = (s_cap || l_cap_edge) && rise;
  wire fall_set = (s_cap || l_cap_edge) && fall;

  // ****************************************
  // input conditioning
  // ****************************************
  irct_edge_filter u_filter (
    .clock      (clock),
    .reset      (reset),
    .tick       (s_tick),
    .sample_in  (shared_ctl_r[irct_pkg::B_COMB] ? capture_input_pin_b
                                                : capture_input_pin_a),
    .width_sel  (shared_ctl_r[irct_pkg::B_SUB_HI:irct_pkg::B_SUB_LO]),
    .edge_sel   (shared_ctl_r[irct_pkg::B_LOG_HI:irct_pkg::B_LOG_LO]),
    .rise_pulse (rise),
    .fall_pulse (fall)
  );
  assign edge_any = rise || fall;

  always_ff @(posedge clock) begin
    if (reset) begin
      pre_r      <= 3'h0;
      short_en_q <= 1'b0;
      long_en_q  <= 1'b0;
      long_ign_q <= 1'b0;
    end else begin
      pre_r      <= pre_r + 3'h1;
      short_en_q <= s_en;
      long_en_q  <= l_en;
      long_ign_q <= l_ign;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      short_low_r  <= irct_pkg::RELOAD_RST;
      short_high_r <= irct_pkg::RELOAD_RST;
      long_lower_r <= irct_pkg::RELOAD_RST;
      long_upper_r <= irct_pkg::RELOAD_RST;
    end else if (we) begin
      case (addr)
        irct_pkg::OFF_SHORT_LOW:  short_low_r  <= wdata;
        irct_pkg::OFF_SHORT_HIGH: short_high_r <= wdata;
        irct_pkg::OFF_LONG_LOWER: long_lower_r <= wdata;
        irct_pkg::OFF_LONG_UPPER: long_upper_r <= wdata;
        default: ;
      endcase
    end
  end

  // set wins over a clearing write
  always_comb begin
    short_ctl_nxt = short_ctl_r;
    if (wr_sc) begin
      short_ctl_nxt = wdata;
      short_ctl_nxt[irct_pkg::B_TOUT] = short_ctl_r[irct_pkg::B_TOUT]
                                        & ~wdata[irct_pkg::B_TOUT];
    end
    if (s_term && s_single)
      short_ctl_nxt[irct_pkg::B_EN] = 1'b0;
    if (pingpong && l_term && l_single)
      short_ctl_nxt[irct_pkg::B_EN] = 1'b1;
    if (s_tout_set)
      short_ctl_nxt[irct_pkg::B_TOUT] = 1'b1;
  end

  always_comb begin
    long_ctl_nxt = long_ctl_r;
    if (wr_lc) begin
      long_ctl_nxt = wdata;
      long_ctl_nxt[irct_pkg::B_TOUT] = long_ctl_r[irct_pkg::B_TOUT]
                                       & ~wdata[irct_pkg::B_TOUT];
    end
    if (l_term && l_single)
      long_ctl_nxt[irct_pkg::B_EN] = 1'b0;
    if (pingpong && s_term && s_single)
      long_ctl_nxt[irct_pkg::B_EN] = 1'b1;
    if (l_tout_set)
      long_ctl_nxt[irct_pkg::B_TOUT] = 1'b1;
  end

  // low two bits are edge flags in measure mode, initial levels otherwise
  always_comb begin
    shared_ctl_nxt = shared_ctl_r;
    if (wr_xc) begin
      shared_ctl_nxt = wdata;
      if (wdata[irct_pkg::B_MODE])
        shared_ctl_nxt[1:0] = shared_ctl_r[1:0] & ~wdata[1:0];
    end
    if (rise_set)
      shared_ctl_nxt[irct_pkg::B_INIT_S] = 1'b1;
    if (fall_set)
      shared_ctl_nxt[irct_pkg::B_INIT_L] = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      short_ctl_r  <= irct_pkg::CTL_RST;
      shared_ctl_r <= irct_pkg::CTL_RST;
      long_ctl_r   <= irct_pkg::CTL_RST;
    end else begin
      short_ctl_r  <= short_ctl_nxt;
      shared_ctl_r <= shared_ctl_nxt;
      long_ctl_r   <= long_ctl_nxt;
    end
  end

  // ****************************************
  // short timer
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      short_st_r  <= irct_pkg::ST_IDLE;
      short_cnt_r <= 8'h00;
    end else if (!s_en) begin
      short_st_r <= irct_pkg::ST_IDLE;
    end else if (s_start) begin
      short_st_r <= mode ? irct_pkg::ST_ARMED : irct_pkg::ST_COUNT;
      if (!mode)
        short_cnt_r <= init_s ? short_high_r : short_low_r;
    end else begin
      case (short_st_r)
        irct_pkg::ST_ARMED: begin
          if (edge_any) begin
            short_st_r  <= irct_pkg::ST_COUNT;
            short_cnt_r <= irct_pkg::SHORT_FULL;
          end
        end
        irct_pkg::ST_COUNT: begin
          if (s_cap)
            short_cnt_r <= irct_pkg::SHORT_FULL;
          else if (s_term && s_single)
            short_st_r <= irct_pkg::ST_IDLE;
          else if (s_term)
            short_cnt_r <= short_out_r ? short_low_r : short_high_r;
          else if (s_tick)
            short_cnt_r <= short_cnt_r - 8'h01;
        end
        default: short_st_r <= irct_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset)
      short_out_r <= 1'b1;
    else if (!s_en)
      short_out_r <= ~init_s;
    else if (s_start)
      short_out_r <= init_s;
    else if (s_term)
      short_out_r <= ~short_out_r;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      short_rise_r <= 8'h00;
      short_fall_r <= 8'h00;
    end else if (s_cap) begin
      if (rise)
        short_rise_r <= ~short_cnt_r;
      if (fall)
        short_fall_r <= ~short_cnt_r;
    end
  end

  // ****************************************
  // long timer
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      long_st_r  <= irct_pkg::ST_IDLE;
      long_cnt_r <= 16'h0000;
    end else if (!l_en) begin
      long_st_r <= irct_pkg::ST_IDLE;
    end else if (l_start) begin
      long_st_r <= mode ? irct_pkg::ST_ARMED : irct_pkg::ST_COUNT;
      if (!mode)
        long_cnt_r <= {long_upper_r, long_lower_r};
    end else if (l_rearm) begin
      long_st_r <= irct_pkg::ST_ARMED;
    end else begin
      case (long_st_r)
        irct_pkg::ST_ARMED: begin
          if (l_cap_first) begin
            long_st_r  <= irct_pkg::ST_COUNT;
            long_cnt_r <= {long_upper_r, long_lower_r};
          end
        end
        irct_pkg::ST_COUNT: begin
          if (l_cap_edge)
            long_cnt_r <= irct_pkg::LONG_FULL;
          else if (l_term && l_single)
            long_st_r <= irct_pkg::ST_IDLE;
          else if (l_term)
            long_cnt_r <= {long_upper_r, long_lower_r};
          else if (l_tick)
            long_cnt_r <= long_cnt_r - 16'h0001;
        end
        default: long_st_r <= irct_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset)
      long_out_r <= 1'b1;
    else if (!mode && sub[1])
      long_out_r <= sub[0];
    else if (!l_en)
      long_out_r <= ~init_l;
    else if (l_start)
      long_out_r <= init_l;
    else if (l_term)
      long_out_r <= ~long_out_r;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      lcap_lower_r <= 8'h00;
      lcap_upper_r <= 8'h00;
    end else if (l_cap_first || l_cap_edge || l_cap_tout) begin
      {lcap_upper_r, lcap_lower_r} <= ~long_cnt_r;
    end
  end

  // ****************************************
  // pins, requests and read port
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      short_output_pin    <= 1'b0;
      long_output_pin     <= 1'b0;
      combined_output_pin <= 1'b0;
      short_irq           <= 1'b0;
      long_irq            <= 1'b0;
    end else begin
      short_output_pin <= short_ctl_r[irct_pkg::B_PIN] ? short_out_r
                                                       : port_short;
      long_output_pin  <= long_ctl_r[irct_pkg::B_PIN] ? long_out_r
                                                      : port_long;
      combined_output_pin <= (!mode && shared_ctl_r[irct_pkg::B_COMB]) ?
        comb_of(shared_ctl_r[irct_pkg::B_LOG_HI:irct_pkg::B_LOG_LO],
                short_out_r, long_out_r) : port_comb;
      short_irq <= (s_tout_set && short_ctl_r[irct_pkg::B_TOUTM])
                   || (s_cap && short_ctl_r[irct_pkg::B_CAPM]);
      long_irq  <= (l_tout_set && long_ctl_r[irct_pkg::B_TOUTM])
                   || ((l_cap_edge || l_cap_tout)
                       && long_ctl_r[irct_pkg::B_CAPM]);
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !re) begin
      rdata <= 8'h00;
    end else begin
      case (addr)
        irct_pkg::OFF_SHORT_LOW:  rdata <= short_low_r;
        irct_pkg::OFF_SHORT_HIGH: rdata <= short_high_r;
        irct_pkg::OFF_LONG_LOWER: rdata <= long_lower_r;
        irct_pkg::OFF_LONG_UPPER: rdata <= long_upper_r;
        irct_pkg::OFF_SHORT_RISE: rdata <= short_rise_r;
        irct_pkg::OFF_SHORT_FALL: rdata <= short_fall_r;
        irct_pkg::OFF_LCAP_LOWER: rdata <= lcap_lower_r;
        irct_pkg::OFF_LCAP_UPPER: rdata <= lcap_upper_r;
        irct_pkg::OFF_SHORT_CTL:  rdata <= short_ctl_r;
        irct_pkg::OFF_SHARED_CTL: rdata <= shared_ctl_r;
        irct_pkg::OFF_LONG_CTL:   rdata <= long_ctl_r;
        default:                  rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_short_idle_level: assert property (
    !mode && !s_en |=> short_out_r == !$past(init_s))
    else $error("short output not inverse of initial bit");
  a_short_start_load: assert property (
    !mode && s_start |=> short_out_r == $past(init_s) && short_cnt_r ==
      ($past(init_s) ? $past(short_high_r) : $past(short_low_r)))
    else $error("short timer start load wrong");
  a_short_single_stop: assert property (
    s_term && s_single |=> !s_en && short_ctl_r[irct_pkg::B_TOUT])
    else $error("one-shot short timer did not stop and flag");
  a_short_zero_wrap: assert property (
    !mode && s_run && s_tick && short_cnt_r == 8'h00
      |=> short_cnt_r == 8'hFF)
    else $error("short timer did not wrap from zero");
  a_short_capture: assert property (
    s_cap && rise |=> short_rise_r == ~$past(short_cnt_r)
      && short_cnt_r == 8'hFF && shared_ctl_r[irct_pkg::B_INIT_S])
    else $error("short capture wrong");
  a_long_force: assert property (
    !mode && sub == irct_pkg::SUB_FORCE0 |=> !long_out_r)
    else $error("long output not forced low");
  a_long_load: assert property (
    !mode && l_start |=> long_cnt_r == $past({long_upper_r, long_lower_r}))
    else $error("long timer load wrong");
  // divided ticks may leave the count at zero for several clocks
  a_long_zero_flag: assert property (
    l_zero_m && !l_cap_edge && !l_rearm
      |=> long_ctl_r[irct_pkg::B_TOUT] && long_cnt_r == 16'h0000)
    else $error("long measure timeout not flagged");
  a_long_zero_wrap: assert property (
    l_run && l_tick && long_cnt_r == 16'h0000 && !l_cap_edge && !l_rearm
      |=> long_cnt_r == 16'hFFFF)
    else $error("long timer did not wrap from zero");
  a_ping_handover: assert property (
    pingpong && s_term && s_single |=> !s_en && l_en ##1 l_start == 1'b0)
    else $error("ping-pong handover failed");
  a_comb_pin: assert property (
    !mode && shared_ctl_r[irct_pkg::B_COMB] && shared_ctl_r[5:4] == 2'b00
      |=> combined_output_pin == $past(short_out_r & long_out_r))
    else $error("combined pin wrong");

  c_short_repeat: cover property (s_term && !s_single);
  c_long_ignore:  cover property (l_cap_tout);
  c_pingpong:     cover property (pingpong && l_term);

endmodule : irct_top

// ---- sim/irct_ir_source.sv ----
`timescale 1ns/1ns
module irct_ir_source (
  // clock and trigger
  input  wire logic       clock,
  input  wire logic       fire,
  input  wire logic [7:0] width,
  // demodulated receiver line
  output logic            ir_level
);
  logic [7:0] left_r = 8'h00;
  // quiet receiver idles low between bursts
  always_ff @(posedge clock) begin
    if (fire) begin
      left_r <= width;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
  end
  assign ir_level = (left_r != 8'h00);
endmodule : irct_ir_source

// ---- sim/test_irct_top.sv ----
`timescale 1ns/1ns
module test_irct_top;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       we = 1'b0;
  logic       re = 1'b0;
  logic       fire = 1'b0;
  logic [7:0] rdata, v, e;
  logic       pin_a, s_pin, l_pin, c_pin, s_irq, l_irq, a, b;
  int         n_fail = 0;
  int         compares = 0;
  int         irq_s = 0;
  int         irq_l = 0;
  irct_top dut_u (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
    .we(we), .re(re), .rdata(rdata), .capture_input_pin_a(pin_a),
    .capture_input_pin_b(1'b0), .port_short(1'b0), .port_long(1'b0),
    .port_comb(1'b0), .short_output_pin(s_pin), .long_output_pin(l_pin),
    .combined_output_pin(c_pin), .short_irq(s_irq), .long_irq(l_irq));
  irct_ir_source src_u (.clock(clock), .fire(fire), .width(8'h0A),
    .ir_level(pin_a));
  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (s_irq === 1'b1) irq_s++;
    if (l_irq === 1'b1) irq_l++;
  end
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clock);
    addr <= ad; wdata <= d; we <= 1'b1;
    @(posedge clock);
    we <= 1'b0;
  endtask : wr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [3:0] ad, input logic [7:0] exp);
    @(posedge clock);
    addr <= ad; re <= 1'b1;
    @(posedge clock);
    re <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task automatic pins(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : pins
  task automatic close_out;
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    rd(4'h8, 8'h00);
    rd(4'hA, 8'h00);
    rd(4'hB, 8'h00);
    wr(4'h8, 8'h01);
    wr(4'hA, 8'h01);
    for (int lg = 0; lg < 4; lg++) begin
      for (int k = 0; k < 4; k++) begin
        wr(4'h9, {2'b01, 2'(lg), 2'b00, 2'(k)});
        pins(3);
        a = ~k[1];
        b = ~k[0];
        e = {7'h00, lg == 0 ? a & b : lg == 1 ? a | b : lg == 2 ?
             ~(a | b) : ~(a & b)};
        chk({7'h00, s_pin}, {7'h00, a});
        chk({7'h00, l_pin}, {7'h00, b});
        chk({7'h00, c_pin}, e);
      end
    end
    wr(4'h9, 8'h08);
    pins(3);
    chk({7'h00, l_pin}, 8'h00);
    wr(4'h9, 8'h0D);
    pins(3);
    chk({7'h00, l_pin}, 8'h01);
    wr(4'h9, 8'h00);
    wr(4'h0, 8'h05);
    wr(4'h8, 8'hC3);
    pins(4);
    chk({7'h00, s_pin}, 8'h00);
    pins(20);
    chk({7'h00, s_pin}, 8'h01);
    chk(8'(irq_s), 8'h01);
    rd(4'h8, 8'h63);
    wr(4'h8, 8'h43);
    rd(4'h8, 8'h63);
    wr(4'h8, 8'h63);
    rd(4'h8, 8'h43);
    wr(4'h2, 8'h04);
    wr(4'hA, 8'hC3);
    pins(4);
    chk({7'h00, l_pin}, 8'h00);
    pins(20);
    chk({7'h00, l_pin}, 8'h01);
    chk(8'(irq_l), 8'h01);
    rd(4'hA, 8'h63);
    wr(4'hA, 8'h63);
    wr(4'h9, 8'h04);
    wr(4'h8, 8'hC3);
    pins(14);
    wr(4'h9, 8'h00);
    pins(20);
    chk(8'(irq_s), 8'h03);
    chk(8'(irq_l), 8'h02);
    rd(4'h8, 8'h63);
    rd(4'hA, 8'h63);
    wr(4'h0, 8'hFF);
    wr(4'h1, 8'hFF);
    wr(4'h9, 8'hA0);
    wr(4'h8, 8'h84);
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    pins(30);
    rd(4'h9, 8'hA1);
    chk(8'(irq_s), 8'h04);
    @(posedge clock);
    addr <= 4'h5; re <= 1'b1;
    @(posedge clock);
    re <= 1'b0;
    #1 v = rdata;
    compares++;
    if (v < 8'h08 || v > 8'h0B) begin
      n_fail++;
      $display("CHECK FAILED %0t capture %h", $time, v);
    end
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    close_out();
  end
endmodule : test_irct_top
